// ===== ric_chk.sv
// assertion checker for the reset and initialisation control block
`timescale 1ns/100ps
`default_nettype none
module ric_chk #(
   parameter GPW = 16 // general purpose pins
) (
   input wire clk_i,
   input wire rst_i,
   input wire hw_rst_n_i,
   input wire bus_mode_strap_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire [GPW-1:0] gp_alt_sel_o,
   input wire [GPW-1:0] gp_oe_o,
   input wire tx_data_oe_o,
   input wire pins_oe_o,
   input wire tx_driver_enable_n_o,
   input wire ebc_rst_o,
   input wire dma_sm_rst_o,
   input wire port_rst_o,
   input wire dma_hold_o,
   input wire chan_active_o,
   input wire [3:0] frame_format_o,
   input wire [7:0] max_frame_len_o
);
   // one clock domain, synchronous reset
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_pins_float: assert property (!hw_rst_n_i |-> !pins_oe_o && tx_driver_enable_n_o)
      else $error("pins driven while reset pin low");
   a_den_track: assert property (hw_rst_n_i ##1 hw_rst_n_i |->
      tx_driver_enable_n_o == $past(rst_i || !tx_data_oe_o)) else $error("driver enable wrong");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   a_reset_state: assert property ($fell(rst_i) |-> ebc_rst_o && dma_sm_rst_o && dma_hold_o &&
      !chan_active_o && frame_format_o == 4'h0 && max_frame_len_o == 8'h00 && gp_oe_o == '0 && !tx_data_oe_o)
      else $error("state after reset wrong");
   a_pin_subrst: assert property (!hw_rst_n_i |=> ebc_rst_o && dma_sm_rst_o && port_rst_o && dma_hold_o)
      else $error("subfunctions not reset by pin");
   a_port_clear: assert property (port_rst_o |=> !tx_data_oe_o) else $error("tx line driven in reset");
   a_strap_gate: assert property (bus_mode_strap_i |-> gp_alt_sel_o[7:0] == 8'h00)
      else $error("local bus pins with strap high");
   // main scenarios
   c_tx_enable: cover property ($rose(tx_data_oe_o));
   c_bus_release: cover property ($fell(ebc_rst_o));
   c_pin_reset: cover property (!hw_rst_n_i);
endmodule // ric_chk
`default_nettype wire

// ===== ric_consts.vh
// constants for the reset and initialisation control block
`ifndef RIC_CONSTS_VH
`define RIC_CONSTS_VH
// register byte offsets
`define RIC_CONF 8'h00
`define RIC_SWRST 8'h04
`define RIC_LCONF 8'h08
`define RIC_MODE1 8'h0C
`define RIC_MODE2 8'h10
`define RIC_PORTCON 8'h14
`define RIC_GP_DIRECTION 8'h18
`define RIC_GPVAL 8'h1C
`define RIC_STATUS 8'h20
`define RIC_ACTION 8'h24
`define RIC_SEL 8'h28
`define RIC_CHCFG 8'h2C
`define RIC_TSCFG 8'h30
// configuration bits
`define RIC_CONF_LBPS 0
`define RIC_CONF_SSPS 1
`define RIC_CONF_TPEN 2
`define RIC_CONF_HOLD 3
`define RIC_CONF_CHEN 4
`define RIC_CONF_RST 32'h0000_0008
// software reset bits
`define RIC_SW_EBC 17
`define RIC_SW_DMA 18
`define RIC_SW_PORT 19
// local bus release bits
`define RIC_LC_EBC 0
`define RIC_LC_DMA 1
// mode1 fields: [3:0] format, [6:4] tx slot, [10:8] rx slot, [14:12] tx shift, [18:16] rx shift, [31:24] max len
`define RIC_M1_RST 32'h0000_0000
`define RIC_M1_MASK 32'hFF07_777F
`define RIC_M1_DDR 32'h0005_3308
`define RIC_M1_SDR_A 32'h0002_4408
`define RIC_M1_SDR_B 32'h0004_2408
`define RIC_M1_CHK 32'h0007_777F
// mode2 bits: 0 rx sample, 1 tx launch, 2 rx sync, 3 tx sync
`define RIC_M2_DDR 4'h8
`define RIC_M2_SDR_A 4'hA
`define RIC_M2_SDR_B 4'h6
// port control bits: 0 clock rate, 1 handshake
`define RIC_PC_DDR 2'h3
`define RIC_PC_CLR 0
// reset values of the channel and slot tables
`define RIC_CH_RST 24'h000003
`define RIC_TS_RST 16'h0000
// frame sync edges needed to resynchronise
`define RIC_SYNC_EDGES 2'h2
`endif

// ===== ric_host.sv
// host processor model, wishbone master of the register port
`timescale 1ns/100ps
`default_nettype none
module ric_host (
   input wire logic clk_i,
   input wire logic wb_ack_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o
);
   // bus idle from time zero
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h0;
   end
   // one classic cycle; request held until ack is sampled, then released
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= a;
      wb_sel_o <= 4'hF;
      wb_dat_o <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_i !== 1'b1 && n < 20);
      q = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      // a slave that never answers ends the run
      if (wb_ack_i !== 1'b1) begin
         $display("MISMATCH %0t bus timeout", $time);
         tb_top.err_total++;
         tb_top.results();
      end
   endtask
endmodule // ric_host
`default_nettype wire

// ===== ric_top.v
// reset and post-reset initialisation control with wishbone register slave
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "ric_consts.vh"
module ric_top #(
   parameter NCH = 32, // logical channels and time slots
   parameter GPW = 16 // general purpose pins
) (
   input wire clk_i, // 10 MHz system clock
   input wire rst_i, // synchronous reset, active high
   input wire hw_rst_n_i, // reset pin, active low
   input wire bus_mode_strap_i, // strap pin, zero selects bus interface mode
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [GPW-1:0] gp_in_i, // general purpose pin levels
   output reg [GPW-1:0] gp_out_o,
   output reg [GPW-1:0] gp_oe_o,
   output reg [GPW-1:0] gp_alt_sel_o, // high where the alternate function owns the pin
   input wire port_rx_clk_i, // terminal port receive clock
   input wire port_rx_data_i, // terminal port receive data
   input wire rx_frame_sync_i, // receive frame sync
   input wire tx_frame_sync_i, // transmit frame sync
   input wire core_tx_data_i, // serial core transmit bit, same clock
   output reg tx_data_o,
   output reg tx_data_oe_o,
   output reg rx_data_o, // received bit forwarded to the core
   output reg rx_clk_o,
   output reg rx_valid_o, // received data accepted
   output reg pins_oe_o, // global output enable of all other pins
   output reg tx_driver_enable_n_o,
   output reg ebc_rst_o, // bus controller and mailbox held in reset
   output reg dma_sm_rst_o, // local dma state machine held in reset
   output reg port_rst_o, // terminal port / serial controller reset
   output reg dma_hold_o,
   output reg chan_active_o,
   output reg [3:0] frame_format_o,
   output reg [7:0] max_frame_len_o
);
   // reset pin synchroniser, asserts at once, releases on the clock
   // the set side is asynchronous so the pins float without waiting for a clock;
   // release passes two flops so every subfunction leaves reset on one edge
   reg hrst_s1_q;
   reg hrst_s2_q;
   always @(posedge clk_i or negedge hw_rst_n_i) begin
      if (!hw_rst_n_i) begin
         hrst_s1_q <= 1'b1;
         hrst_s2_q <= 1'b1;
      end else begin
         hrst_s1_q <= 1'b0;
         hrst_s2_q <= hrst_s1_q;
      end
   end
   wire rst = rst_i | hrst_s2_q; // single internal reset for all subfunctions

   // input synchronisers for pins
   // only the second stage is read by logic, the first may go metastable
   reg [GPW-1:0] gp_s1_q;
   reg [GPW-1:0] gp_s2_q;
   reg [4:0] in_s1_q; // strap, rx clk, rx data, rx sync, tx sync
   reg [4:0] in_s2_q;
   always @(posedge clk_i) begin
      gp_s1_q <= gp_in_i;
      gp_s2_q <= gp_s1_q;
      in_s1_q <= {bus_mode_strap_i, port_rx_clk_i, port_rx_data_i, rx_frame_sync_i, tx_frame_sync_i};
      in_s2_q <= in_s1_q;
   end

   // registers
   // bits not held here read back as zero
   reg [31:0] conf_q;
   reg [31:0] swrst_q;
   reg [1:0] lconf_q;
   reg [31:0] mode1_q;
   reg [3:0] mode2_q;
   reg [1:0] portcon_q;
   reg [GPW-1:0] gp_direction_q;
   reg [GPW-1:0] gpval_q;
   reg [2:0] action_q; // near-end turnaround, external loop, internal echo
   reg [4:0] chsel_q;
   reg [4:0] tssel_q;
   reg [2:0] esx_q; // internal e, s and x bits
   reg strap_q; // strap caught at reset release
   reg [NCH-1:0] rx_idle_q; // receivers in interframe idle
   reg [23:0] ch_q [0:NCH-1]; // channel specification table
   reg [15:0] ts_q [0:NCH-1]; // time slot assignment table
   reg [1:0] rx_edges_q;
   reg [1:0] tx_edges_q;
   reg rx_fs_d1_q;
   reg tx_fs_d1_q;
   integer i;

   // byte-lane merge of write data
   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0] sel;
      begin
         merge = (old & ~{{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}}) |
                 (dat & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}});
      end
   endfunction

   // merged write words, cut on purpose to the width of each narrow register
   wire [31:0] gp_direction_wr = merge({{(32-GPW){1'b0}}, gp_direction_q}, wb_dat_i, wb_sel_i); // direction word
   wire [31:0] gpval_wr = merge({{(32-GPW){1'b0}}, gpval_q}, wb_dat_i, wb_sel_i); // output latch word
   wire [31:0] ch_wr = merge({8'h00, ch_q[chsel_q]}, wb_dat_i, wb_sel_i); // channel word, 24 bits used
   wire [31:0] ts_wr = merge({16'h0000, ts_q[tssel_q]}, wb_dat_i, wb_sel_i); // slot word, 16 bits used

   wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   wire rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   wire sel_ch_ok = ({27'h0, chsel_q} < NCH);
   wire sel_ts_ok = ({27'h0, tssel_q} < NCH);

   // frame profile checks on programmed port settings
   wire ddr_ok = ((mode1_q & `RIC_M1_CHK) == `RIC_M1_DDR) && (mode2_q == `RIC_M2_DDR) &&
                 (portcon_q == `RIC_PC_DDR);
   wire sdr_ok = (((mode1_q & `RIC_M1_CHK) == `RIC_M1_SDR_A) || ((mode1_q & `RIC_M1_CHK) == `RIC_M1_SDR_B)) &&
                 ((mode2_q == `RIC_M2_SDR_A) || (mode2_q == `RIC_M2_SDR_B)) && portcon_q[`RIC_PC_CLR];

   // status word: esx, profile checks, line enables, strap and subfunction resets
   wire [31:0] status_word = {21'h0, esx_q, sdr_ok, ddr_ok, tx_data_oe_o, rx_valid_o,
                              strap_q, port_rst_o, dma_sm_rst_o, ebc_rst_o};

   // register writes and reset defaults
   // a write lands on the edge that takes the request; ack rises on that same edge
   always @(posedge clk_i) begin
      if (rst) begin
         conf_q <= `RIC_CONF_RST;
         swrst_q <= 32'h0000_0000;
         lconf_q <= 2'h0;
         mode1_q <= `RIC_M1_RST;
         mode2_q <= 4'h0;
         portcon_q <= 2'h0;
         gp_direction_q <= {GPW{1'b0}};
         gpval_q <= {GPW{1'b0}};
         action_q <= 3'h0;
         chsel_q <= 5'h00;
         tssel_q <= 5'h00;
         esx_q <= 3'h0;
         rx_idle_q <= {NCH{1'b1}};
         for (i = 0; i < NCH; i = i + 1) begin
            ch_q[i] <= `RIC_CH_RST;
            ts_q[i] <= `RIC_TS_RST;
         end
      end else if (wr) begin
         case (wb_adr_i)
            `RIC_CONF: conf_q <= merge(conf_q, wb_dat_i, wb_sel_i) & 32'h0000_001F;
            `RIC_SWRST: swrst_q <= merge(swrst_q, wb_dat_i, wb_sel_i) & 32'h000E_0000;
            `RIC_LCONF: lconf_q <= wb_sel_i[0] ? wb_dat_i[1:0] : lconf_q;
            `RIC_MODE1: mode1_q <= merge(mode1_q, wb_dat_i, wb_sel_i) & `RIC_M1_MASK;
            `RIC_MODE2: mode2_q <= wb_sel_i[0] ? wb_dat_i[3:0] : mode2_q;
            `RIC_PORTCON: portcon_q <= wb_sel_i[0] ? wb_dat_i[1:0] : portcon_q;
            `RIC_GP_DIRECTION: gp_direction_q <= gp_direction_wr[GPW-1:0];
            `RIC_GPVAL: gpval_q <= gpval_wr[GPW-1:0];
            `RIC_ACTION: action_q <= wb_sel_i[0] ? wb_dat_i[2:0] : action_q;
            `RIC_SEL: begin
               if (wb_sel_i[0]) chsel_q <= wb_dat_i[4:0];
               if (wb_sel_i[1]) tssel_q <= wb_dat_i[12:8];
            end
            `RIC_CHCFG: begin
               if (sel_ch_ok) ch_q[chsel_q] <= ch_wr[23:0];
               if (sel_ch_ok && wb_sel_i[0] && !wb_dat_i[0]) rx_idle_q[chsel_q] <= 1'b0;
            end
            `RIC_TSCFG: begin
               if (sel_ts_ok) ts_q[tssel_q] <= ts_wr[15:0];
            end
            default: begin
            end
         endcase
      end
   end

   // wishbone answer: ack one cycle after the request, unmapped reads zero
   // read data stands only in the ack cycle and is zero otherwise
   always @(posedge clk_i) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= (wb_cyc_i & wb_stb_i & ~wb_ack_o);
         wb_dat_o <= 32'h0000_0000;
         if (rd) begin
            case (wb_adr_i)
               `RIC_CONF: wb_dat_o <= conf_q;
               `RIC_SWRST: wb_dat_o <= swrst_q;
               `RIC_LCONF: wb_dat_o <= {30'h0, lconf_q};
               `RIC_MODE1: wb_dat_o <= mode1_q;
               `RIC_MODE2: wb_dat_o <= {28'h0, mode2_q};
               `RIC_PORTCON: wb_dat_o <= {30'h0, portcon_q};
               `RIC_GP_DIRECTION: wb_dat_o <= {16'h0, gp_direction_q};
               `RIC_GPVAL: wb_dat_o <= {16'h0, (gp_direction_q & gpval_q) | (~gp_direction_q & gp_s2_q)};
               `RIC_STATUS: wb_dat_o <= status_word;
               `RIC_ACTION: wb_dat_o <= {29'h0, action_q};
               `RIC_SEL: wb_dat_o <= {19'h0, tssel_q, 3'h0, chsel_q};
               `RIC_CHCFG: wb_dat_o <= sel_ch_ok ? {7'h0, rx_idle_q[chsel_q], ch_q[chsel_q]} : 32'h0000_0000;
               `RIC_TSCFG: wb_dat_o <= sel_ts_ok ? {16'h0, ts_q[tssel_q]} : 32'h0000_0000;
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // strap caught while reset is applied, kept after release
   always @(posedge clk_i) begin
      if (rst) begin
         strap_q <= in_s2_q[4];
      end
   end

   // subfunction resets: local bus parts need strap low and host release
   // a software reset bit acts like the pin for its own subfunction only
   always @(posedge clk_i) begin
      if (rst) begin
         ebc_rst_o <= 1'b1;
         dma_sm_rst_o <= 1'b1;
         port_rst_o <= 1'b1;
      end else begin
         ebc_rst_o <= strap_q | swrst_q[`RIC_SW_EBC] | ~lconf_q[`RIC_LC_EBC];
         dma_sm_rst_o <= strap_q | swrst_q[`RIC_SW_DMA] |
                         ~(lconf_q[`RIC_LC_DMA] & conf_q[`RIC_CONF_LBPS]);
         port_rst_o <= swrst_q[`RIC_SW_PORT];
      end
   end

   // general purpose port and alternate function selection
   // an alternate function only takes a byte lane where software selected it
   always @(posedge clk_i) begin
      if (rst) begin
         gp_out_o <= {GPW{1'b0}};
         gp_oe_o <= {GPW{1'b0}};
         gp_alt_sel_o <= {GPW{1'b0}};
      end else begin
         gp_out_o <= gpval_q;
         gp_oe_o <= gp_direction_q;
         gp_alt_sel_o <= {{(GPW/2){conf_q[`RIC_CONF_SSPS]}},
                          {(GPW/2){conf_q[`RIC_CONF_LBPS] & ~strap_q}}};
      end
   end

   // frame sync resynchronisation, two rising edges per direction
   // the port's software reset restarts the count, so the line
   // floats again until two fresh frame syncs are seen
   always @(posedge clk_i) begin
      if (rst | port_rst_o) begin
         rx_fs_d1_q <= 1'b0;
         tx_fs_d1_q <= 1'b0;
         rx_edges_q <= 2'h0;
         tx_edges_q <= 2'h0;
      end else begin
         rx_fs_d1_q <= in_s2_q[1];
         tx_fs_d1_q <= in_s2_q[0];
         if (in_s2_q[1] && !rx_fs_d1_q && rx_edges_q != `RIC_SYNC_EDGES)
            rx_edges_q <= rx_edges_q + 2'h1;
         if (in_s2_q[0] && !tx_fs_d1_q && tx_edges_q != `RIC_SYNC_EDGES)
            tx_edges_q <= tx_edges_q + 2'h1;
      end
   end

   // port receive path always connected, data accepted only after resync
   // received bits are forwarded but flagged invalid until then
   always @(posedge clk_i) begin
      if (rst) begin
         rx_clk_o <= 1'b0;
         rx_data_o <= 1'b0;
         rx_valid_o <= 1'b0;
      end else begin
         rx_clk_o <= in_s2_q[3];
         rx_data_o <= in_s2_q[2];
         rx_valid_o <= (rx_edges_q == `RIC_SYNC_EDGES) & conf_q[`RIC_CONF_TPEN];
      end
   end

   // transmit pin fed from the serial core only, floated until resync
   // the port's software reset floats the line on the next edge; the pin floats it at once through the driver enable
   always @(posedge clk_i) begin
      if (rst | port_rst_o) begin
         tx_data_o <= 1'b1;
         tx_data_oe_o <= 1'b0;
      end else begin
         tx_data_o <= core_tx_data_i;
         tx_data_oe_o <= (tx_edges_q == `RIC_SYNC_EDGES);
      end
   end

   // pin float and driver enable during reset, cleared asynchronously by the reset pin, on the clock by rst_i
   always @(posedge clk_i or posedge hrst_s2_q) begin
      if (hrst_s2_q) begin
         pins_oe_o <= 1'b0;
         tx_driver_enable_n_o <= 1'b1;
      end else begin
         pins_oe_o <= ~rst_i;
         tx_driver_enable_n_o <= rst_i | ~tx_data_oe_o;
      end
   end

   // channel processing status and global frame fields
   // hold wins over channel enable so no channel runs while dma is held
   always @(posedge clk_i) begin
      if (rst) begin
         dma_hold_o <= 1'b1;
         chan_active_o <= 1'b0;
         frame_format_o <= 4'h0;
         max_frame_len_o <= 8'h00;
      end else begin
         dma_hold_o <= conf_q[`RIC_CONF_HOLD];
         chan_active_o <= conf_q[`RIC_CONF_CHEN] & ~conf_q[`RIC_CONF_HOLD];
         frame_format_o <= mode1_q[3:0];
         max_frame_len_o <= mode1_q[31:24];
      end
   end
endmodule // ric_top
`default_nettype wire

// ===== tb_top.sv
// testbench for the reset and initialisation control block
`timescale 1ns/100ps
`default_nettype none
`include "ric_consts.vh"
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hw_n = 1'b1;
   logic strap = 1'b0;
   logic core = 1'b0;
   logic rxd = 1'b0;
   logic rfs = 1'b0;
   logic tfs = 1'b0;
   logic [15:0] gp_in = 16'h1234;
   wire cyc, stb, we, ack, txd, txoe, rxdo, rxco, rxv, poe, den_n, xrst, drst, prst, hold, act;
   wire [7:0] adr;
   wire [7:0] mfl;
   wire [31:0] wdat;
   wire [31:0] rdat;
   wire [15:0] gp_out, gp_oe, alt;
   wire [3:0] ff, sel;
   int err_total = 0;
   int num_checks = 0;
   int i;
   logic [31:0] q;
   // frame settings: double rate, both single rate readings, one bad rx slot
   logic [31:0] m1 [4] = '{`RIC_M1_DDR, `RIC_M1_SDR_A, `RIC_M1_SDR_B, `RIC_M1_DDR ^ 32'h0000_0100};
   logic [3:0] m2 [4] = '{`RIC_M2_DDR, `RIC_M2_SDR_A, `RIC_M2_SDR_B, `RIC_M2_DDR};
   logic [1:0] pc [4] = '{2'h3, 2'h1, 2'h1, 2'h3};
   logic [1:0] ok [4] = '{2'b01, 2'b10, 2'b10, 2'b00};
   // 10 MHz clock
   always #50 clk_i = ~clk_i;
   ric_host host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
      .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
   ric_top dut (.clk_i(clk_i), .rst_i(rst_i), .hw_rst_n_i(hw_n), .bus_mode_strap_i(strap), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .gp_in_i(gp_in), .gp_out_o(gp_out), .gp_oe_o(gp_oe), .gp_alt_sel_o(alt),
      .port_rx_clk_i(rxd), .port_rx_data_i(rxd), .rx_frame_sync_i(rfs), .tx_frame_sync_i(tfs),
      .core_tx_data_i(core), .tx_data_o(txd), .tx_data_oe_o(txoe), .rx_data_o(rxdo), .rx_clk_o(rxco),
      .rx_valid_o(rxv), .pins_oe_o(poe), .tx_driver_enable_n_o(den_n), .ebc_rst_o(xrst), .dma_sm_rst_o(drst),
      .port_rst_o(prst), .dma_hold_o(hold), .chan_active_o(act), .frame_format_o(ff), .max_frame_len_o(mfl));
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic eq(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      host.xfer(1'b1, a, d, r);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0, q);
      eq(q, e);
   endtask
   // one frame sync pulse, transmit side when t is high
   task automatic pulse(input logic t);
      tfs <= t;
      rfs <= !t;
      tk(4);
      tfs <= 1'b0;
      rfs <= 1'b0;
      tk(4);
   endtask
   task automatic results;
      if (err_total == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // main sequence
   initial begin
      tk(16);
      rst_i <= 1'b0;
      tk(2);
      eq({xrst, drst, prst, hold, act, txoe, poe, den_n}, 8'b1101_0011);
      eq({gp_oe, alt}, 32'h0);
      eq({ff, mfl}, 12'h000);
      rc(`RIC_CONF, `RIC_CONF_RST);
      rc(`RIC_MODE1, `RIC_M1_RST);
      rc(`RIC_ACTION, 32'h0);
      rc(`RIC_CHCFG, 32'h0100_0000 | `RIC_CH_RST);
      wr(`RIC_SEL, 32'h0000_1F1F);
      rc(`RIC_CHCFG, 32'h0100_0000 | `RIC_CH_RST);
      rc(`RIC_TSCFG, 32'h0);
      rc(8'hFC, 32'h0);
      // release bus controller, then dma with its pin select
      wr(`RIC_LCONF, 32'h1);
      tk(2);
      eq({xrst, drst}, 2'b01);
      wr(`RIC_CONF, `RIC_CONF_RST | 32'h7);
      wr(`RIC_LCONF, 32'h3);
      tk(2);
      eq({xrst, drst}, 2'b00);
      eq(alt, 16'hFFFF);
      wr(`RIC_GP_DIRECTION, 32'h00FF);
      wr(`RIC_GPVAL, 32'hA5A5);
      tk(2);
      eq({gp_oe, gp_out}, 32'h00FF_A5A5);
      rc(`RIC_GPVAL, 32'h12A5);
      wr(`RIC_CONF, 32'h0000_0017);
      tk(2);
      eq({hold, act}, 2'b01);
      for (i = 0; i < 4; i++) begin
         wr(`RIC_MODE1, m1[i]);
         wr(`RIC_MODE2, m2[i]);
         wr(`RIC_PORTCON, pc[i]);
         host.xfer(1'b0, `RIC_STATUS, 32'h0, q);
         eq(q[7:6], ok[i]);
         eq(ff, 4'h8);
      end
      // frame sync resynchronisation
      pulse(1'b1);
      eq(txoe, 1'b0);
      pulse(1'b1);
      eq({txoe, den_n}, 2'b10);
      pulse(1'b0);
      pulse(1'b0);
      core <= 1'b1;
      rxd <= 1'b1;
      tk(4);
      eq({rxv, txd, rxdo, rxco}, 4'hF);
      // software resets of subfunctions
      wr(`RIC_SWRST, 32'h0008_0000);
      tk(3);
      eq({prst, txoe, xrst}, 3'b100);
      wr(`RIC_SWRST, 32'h0002_0000);
      tk(2);
      eq({xrst, prst}, 2'b10);
      wr(`RIC_SWRST, 32'h0);
      tk(2);
      eq({xrst, drst, prst}, 3'b000);
      // reset pin in mid-run
      hw_n <= 1'b0;
      #10;
      eq({poe, den_n}, 2'b01);
      tk(3);
      hw_n <= 1'b1;
      tk(4);
      eq({xrst, drst, prst, alt}, 19'h60000);
      rc(`RIC_MODE1, `RIC_M1_RST);
      // strap high keeps the local bus pins general purpose
      rst_i <= 1'b1;
      strap <= 1'b1;
      tk(16);
      rst_i <= 1'b0;
      tk(2);
      wr(`RIC_CONF, `RIC_CONF_RST | 32'h3);
      tk(4);
      eq(alt, 16'hFF00);
      results();
   end
endmodule // tb_top
bind ric_top ric_chk #(.GPW(GPW)) chk (.clk_i(clk_i), .rst_i(rst_i), .hw_rst_n_i(hw_rst_n_i),
   .bus_mode_strap_i(bus_mode_strap_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .gp_alt_sel_o(gp_alt_sel_o), .gp_oe_o(gp_oe_o), .tx_data_oe_o(tx_data_oe_o),
   .pins_oe_o(pins_oe_o), .tx_driver_enable_n_o(tx_driver_enable_n_o), .ebc_rst_o(ebc_rst_o),
   .dma_sm_rst_o(dma_sm_rst_o), .port_rst_o(port_rst_o), .dma_hold_o(dma_hold_o), .chan_active_o(chan_active_o),
   .frame_format_o(frame_format_o), .max_frame_len_o(max_frame_len_o));
`default_nettype wire
